// File: eil_defines.svh
// Register map, field positions, reset values and bus constants of the external interrupt latch
`ifndef EIL_DEFINES_SVH
`define EIL_DEFINES_SVH

// ==========================================
// Bus
`define EIL_ADDR_W        8
`define EIL_DATA_W        32
`define EIL_HSIZE_WORD    3'h2
`define EIL_HRESP_OKAY    1'h0

// ==========================================
// Register offsets (byte addresses)
`define EIL_OFS_CTRL      8'h00
`define EIL_OFS_INT_STAT  8'h04
`define EIL_OFS_INT_CLR   8'h08
`define EIL_OFS_INT_EN    8'h0c

// ==========================================
// Status and control field positions
`define EIL_CTRL_TRIG     0
`define EIL_CTRL_MASK     1
`define EIL_CTRL_ACK      2
`define EIL_CTRL_FLAG     3
`define EIL_CTRL_PIN      4

// ==========================================
// Interrupt event bits
`define EIL_EV_LATCH      0
`define EIL_EV_RETURN     1
`define EIL_EV_W          2

// ==========================================
// Reset values
`define EIL_CTRL_RST      1'h0
`define EIL_INT_EN_RST    2'h0
`define EIL_PIN_IDLE      1'h1

`endif

// File: eil_pkg.sv
// Types shared by the external interrupt latch files
`include "eil_defines.svh"

package eil_pkg;

	// Register write strobe from the bus slave
	typedef struct packed {
		logic                     en;
		logic [`EIL_ADDR_W-1:0]   addr;
		logic [`EIL_DATA_W-1:0]   data;
	} eil_bus_wr_t;

	// Synchronised pin and its transitions
	typedef struct packed {
		logic level;
		logic fall;
		logic rise;
	} eil_pin_ev_t;

	// Software control bits
	typedef struct packed {
		logic trig_sel;
		logic mask;
	} eil_ctrl_t;

endpackage : eil_pkg

// File: eil_pin_sync.sv
// Two-stage synchroniser and transition detector for the interrupt pin
`timescale 1ns/10ps
`include "eil_defines.svh"

module eil_pin_sync (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Pin
	input  wire logic          pin_n,
	// Synchronised result
	output eil_pkg::eil_pin_ev_t ev
);

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;
	logic [2:0] arm_q;
	logic [2:0] arm_d;

	// ==========================================
	// Synchroniser
	always_comb begin
		meta_d = pin_n;
		sync_d = meta_q;
		prev_d = sync_q;
		// Edge detect armed once the chain holds real pin samples
		arm_d  = {arm_q[1:0], 1'h1};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= `EIL_PIN_IDLE;
			sync_q <= `EIL_PIN_IDLE;
			prev_q <= `EIL_PIN_IDLE;
			arm_q  <= 3'h0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			arm_q  <= arm_d;
		end
	end

	// ==========================================
	// Transitions on the synchronised value only
	// Pin held low through reset gives no edge
	assign ev.level = sync_q;
	assign ev.fall  = prev_q & ~sync_q & arm_q[2];
	assign ev.rise  = ~prev_q & sync_q & arm_q[2];

endmodule : eil_pin_sync

// File: eil_ahb_slave.sv
// AHB-Lite slave front end: writes with no wait, reads with one wait state
`timescale 1ns/10ps
`include "eil_defines.svh"

module eil_ahb_slave (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [`EIL_DATA_W-1:0] hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic [`EIL_DATA_W-1:0]      hrdata,
	output logic                        hresp,
	// Register side
	output eil_pkg::eil_bus_wr_t        wr,
	output logic [`EIL_ADDR_W-1:0]      rd_addr,
	input  wire logic [`EIL_DATA_W-1:0] rd_data
);

	logic                   acc;
	logic                   wr_pend_q;
	logic                   wr_pend_d;
	logic                   rd_pend_q;
	logic                   rd_pend_d;
	logic                   rdy_q;
	logic                   rdy_d;
	logic [`EIL_ADDR_W-1:0] addr_q;
	logic [`EIL_ADDR_W-1:0] addr_d;
	logic [`EIL_DATA_W-1:0] rdata_q;
	logic [`EIL_DATA_W-1:0] rdata_d;

	assign acc = hsel & htrans[1] & hready;

	// ==========================================
	// Address phase capture, read wait state
	always_comb begin
		wr_pend_d = acc & hwrite & (hsize == `EIL_HSIZE_WORD);
		rd_pend_d = acc & ~hwrite;
		rdy_d     = ~(acc & ~hwrite);
		addr_d    = acc ? haddr[`EIL_ADDR_W-1:0] : addr_q;
		rdata_d   = rd_pend_q ? rd_data : rdata_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'h0;
			rd_pend_q <= 1'h0;
			rdy_q     <= 1'h1;
			addr_q    <= '0;
			rdata_q   <= '0;
		end else begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			rdy_q     <= rdy_d;
			addr_q    <= addr_d;
			rdata_q   <= rdata_d;
		end
	end

	assign hreadyout = rdy_q;
	assign hrdata    = rdata_q;
	assign hresp     = `EIL_HRESP_OKAY;
	assign wr.en     = wr_pend_q;
	assign wr.addr   = addr_q;
	assign wr.data   = hwdata;
	assign rd_addr   = addr_q;

endmodule : eil_ahb_slave

// File: eil_top.sv
// External interrupt latch: pin sensing, request latch, acknowledge, mask and register file
//
// Summary of operation
// - A falling edge on the active-low pin sets the request latch.
// - A vector fetch acknowledge clears the latch that caused it.
// - Writing 1 to the acknowledge bit acts as a vector fetch acknowledge.
// - Reset clears the request latch.
// - Trigger select clear: edges only; set: edges and low level.
// - Edge-only mode: latch holds until acknowledge or reset, then clears at once.
// - Edge-and-level mode: clear needs acknowledge and pin high, any order.
// - Mask bit set keeps the latched request from the CPU.
// - A falling edge after a software acknowledge latches a new request.
// - Current pin level is given to the CPU for branch tests.
// - Acknowledge bit is write-only, reads 0, reset clears it.
// - Mask bit is read/write; 1 disables requests; reset clears it.
// - Trigger select is read/write; 1 edge and level; reset clears it.
// - Read-only flag reads 1 while an event is latched.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "eil_defines.svh"

module eil_top (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [`EIL_DATA_W-1:0] hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic [`EIL_DATA_W-1:0]      hrdata,
	output logic                        hresp,
	// External pin
	input  wire logic                   irq_pin_n,
	// CPU core
	input  wire logic                   vec_fetch_ack,
	output logic                        cpu_irq_req,
	output logic                        pin_level,
	// System interrupt
	output logic                        irq
);

	eil_pkg::eil_bus_wr_t   wr;
	eil_pkg::eil_pin_ev_t   pin;
	eil_pkg::eil_ctrl_t     ctrl_q;
	eil_pkg::eil_ctrl_t     ctrl_d;
	logic [`EIL_ADDR_W-1:0] rd_addr;
	logic [`EIL_DATA_W-1:0] rd_data;
	logic                   sw_ack;
	logic                   any_ack;
	logic                   set_ev;
	logic                   clr_ok;
	logic                   latch_q;
	logic                   latch_d;
	logic                   ack_pend_q;
	logic                   ack_pend_d;
	logic                   req_q;
	logic                   req_d;
	logic [`EIL_EV_W-1:0]   ev;
	logic [`EIL_EV_W-1:0]   stat_q;
	logic [`EIL_EV_W-1:0]   stat_d;
	logic [`EIL_EV_W-1:0]   en_q;
	logic [`EIL_EV_W-1:0]   en_d;
	logic [`EIL_EV_W-1:0]   clr;
	logic                   irq_q;
	logic                   irq_d;

	// ==========================================
	// Write decode helper
	function automatic logic hit(input eil_pkg::eil_bus_wr_t w,
			input logic [`EIL_ADDR_W-1:0] ofs);
		hit = w.en & (w.addr == ofs);
	endfunction : hit

	// ==========================================
	// Bus slave
	eil_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.wr        (wr),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data)
	);

	// ==========================================
	// Pin synchroniser
	// synchronised pin
	eil_pin_sync u_pin (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_n   (irq_pin_n),
		.ev      (pin)
	);

	assign pin_level = pin.level;

	// ==========================================
	// Control register
	always_comb begin
		ctrl_d = ctrl_q;
		if (hit(wr, `EIL_OFS_CTRL)) begin
			ctrl_d.mask     = wr.data[`EIL_CTRL_MASK];
			ctrl_d.trig_sel = wr.data[`EIL_CTRL_TRIG];
		end
	end

	assign sw_ack  = hit(wr, `EIL_OFS_CTRL) & wr.data[`EIL_CTRL_ACK];
	assign any_ack = sw_ack | vec_fetch_ack;

	// ==========================================
	// Request latch
	always_comb begin
		set_ev = pin.fall | (ctrl_q.trig_sel & ~pin.level);
		clr_ok = (any_ack | ack_pend_q) & (~ctrl_q.trig_sel | pin.level);
		if (set_ev) begin
			latch_d = 1'h1;
		end else if (clr_ok) begin
			latch_d = 1'h0;
		end else begin
			latch_d = latch_q;
		end
		ack_pend_d = (any_ack | ack_pend_q) & latch_d & ~set_ev;
		if (ctrl_q.trig_sel & ~pin.level & latch_q) begin
			ack_pend_d = any_ack | ack_pend_q;
		end
		req_d = latch_d & ~ctrl_d.mask;
	end

	// ==========================================
	// Interrupt status, clear and enable
	assign ev[`EIL_EV_LATCH]  = latch_d & ~latch_q;
	assign ev[`EIL_EV_RETURN] = pin.rise;
	assign clr = hit(wr, `EIL_OFS_INT_CLR) ? wr.data[`EIL_EV_W-1:0] : '0;

	always_comb begin
		stat_d = ev | (stat_q & ~clr);
		en_d   = hit(wr, `EIL_OFS_INT_EN) ? wr.data[`EIL_EV_W-1:0] : en_q;
		irq_d  = |(stat_d & en_d);
	end

	// ==========================================
	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= '{trig_sel: `EIL_CTRL_RST, mask: `EIL_CTRL_RST};
			latch_q    <= 1'h0;
			ack_pend_q <= 1'h0;
			req_q      <= 1'h0;
			stat_q     <= '0;
			en_q       <= `EIL_INT_EN_RST;
			irq_q      <= 1'h0;
		end else begin
			ctrl_q     <= ctrl_d;
			latch_q    <= latch_d;
			ack_pend_q <= ack_pend_d;
			req_q      <= req_d;
			stat_q     <= stat_d;
			en_q       <= en_d;
			irq_q      <= irq_d;
		end
	end

	assign cpu_irq_req = req_q;
	assign irq         = irq_q;

	// ==========================================
	// Read mux
	always_comb begin
		rd_data = '0;
		unique case (rd_addr)
			`EIL_OFS_CTRL: begin
				rd_data[`EIL_CTRL_TRIG] = ctrl_q.trig_sel;
				rd_data[`EIL_CTRL_MASK] = ctrl_q.mask;
				rd_data[`EIL_CTRL_ACK]  = 1'h0;
				rd_data[`EIL_CTRL_FLAG] = latch_q;
				rd_data[`EIL_CTRL_PIN]  = pin.level;
			end
			`EIL_OFS_INT_STAT: rd_data[`EIL_EV_W-1:0] = stat_q;
			`EIL_OFS_INT_EN:   rd_data[`EIL_EV_W-1:0] = en_q;
			default:           rd_data = '0;
		endcase
	end

	// ==========================================
	// Checks
	logic first_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_q <= 1'h1;
		end else begin
			first_q <= 1'h0;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	edge_sets_latch_a: assert property (pin.fall |=> latch_q && (cpu_irq_req || ctrl_q.mask))
		else $error("falling edge did not set latch");

	vector_ack_clear_a: assert property (vec_fetch_ack && !ctrl_q.trig_sel && !pin.fall
			|=> !latch_q)
		else $error("vector fetch did not clear latch");

	sw_ack_clear_a: assert property (sw_ack && !ctrl_q.trig_sel && !pin.fall |=> !latch_q)
		else $error("software acknowledge did not clear latch");

	reset_clear_a: assert property (first_q |-> !latch_q && !cpu_irq_req && !irq)
		else $error("latch not clear after reset");

	low_level_a: assert property (ctrl_q.trig_sel && !pin.level [*2] |=> latch_q)
		else $error("low level did not hold latch");

	edge_hold_a: assert property (latch_q && !ctrl_q.trig_sel && !any_ack |=> latch_q)
		else $error("edge latch lost without acknowledge");

	level_release_a: assert property (ctrl_q.trig_sel && latch_q && ack_pend_q && pin.level
			&& !any_ack |=> !latch_q)
		else $error("latch not released after ack and pin high");

	mask_gate_a: assert property (ctrl_q.mask |-> !cpu_irq_req)
		else $error("masked request reached cpu");

	unmask_present_a: assert property (latch_q && !ctrl_q.mask && !$past(first_q)
			|-> cpu_irq_req)
		else $error("unmasked request not presented");

	edge_after_ack_a: assert property (sw_ack ##1 pin.fall |=> latch_q)
		else $error("edge after acknowledge lost");

	ack_reads_zero_a: assert property (hreadyout |-> !hrdata[`EIL_CTRL_ACK])
		else $error("acknowledge bit read as one");

	irq_level_a: assert property (stat_q[`EIL_EV_LATCH] && en_q[`EIL_EV_LATCH]
			&& !clr[`EIL_EV_LATCH] && !hit(wr, `EIL_OFS_INT_EN) |=> irq)
		else $error("enabled event did not raise irq");

	mask_write_a: assert property (hit(wr, `EIL_OFS_CTRL)
			|=> ctrl_q.mask == $past(wr.data[`EIL_CTRL_MASK]))
		else $error("mask write not taken");

	trig_write_a: assert property (hit(wr, `EIL_OFS_CTRL)
			|=> ctrl_q.trig_sel == $past(wr.data[`EIL_CTRL_TRIG]))
		else $error("trigger select write not taken");

	reset_ctrl_a: assert property (first_q |-> !ctrl_q.mask && !ctrl_q.trig_sel)
		else $error("control bits not clear after reset");

	level_pending_a: assert property (ctrl_q.trig_sel && latch_q && !pin.level
			|=> latch_q)
		else $error("level request dropped while pin low");

	ack_remember_a: assert property (sw_ack && ctrl_q.trig_sel && !pin.level && latch_q
			|=> latch_q && ack_pend_q)
		else $error("acknowledge while pin low not remembered");

	edge_beats_ack_a: assert property (pin.fall && any_ack |=> latch_q)
		else $error("edge lost to a simultaneous acknowledge");

	status_on_latch_a: assert property ($rose(latch_q) |-> stat_q[`EIL_EV_LATCH])
		else $error("latch set without status event");

	pin_level_a: assert property (!first_q && !$past(first_q)
			|-> pin_level == $past(irq_pin_n, 2))
		else $error("pin level not two flops behind pin");

endmodule : eil_top

// File: eil_cpu_model.sv
// Behavioural CPU interrupt side that answers the latched request
`timescale 1ns/10ps

module eil_cpu_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Request and acknowledge
	input  wire logic       req,
	input  wire logic       gmask,
	input  wire logic [3:0] lat,
	output logic            ack,
	output logic [15:0]     pc
);
	logic [3:0] cnt;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack <= 1'b0;
			cnt <= 4'h0;
			pc  <= 16'h0;
		end else if (ack) begin
			ack <= 1'b0;
		end else if (req && !gmask) begin
			if (cnt == lat) begin
				ack <= 1'b1;
				cnt <= 4'h0;
				pc <= 16'hfffa;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			cnt <= 4'h0;
		end
	end
endmodule : eil_cpu_model

// File: external_interrupt_latch_bench.sv
// Self-checking bench of the external interrupt latch
`timescale 1ns/10ps
`include "eil_defines.svh"

module external_interrupt_latch_bench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hrdy;
	logic [31:0] hrdata;
	logic        hresp;
	logic        pin_n;
	logic        ack;
	logic        req;
	logic        pin_lvl;
	logic        irq;
	logic        gmask;
	logic [3:0]  lat;
	logic [15:0] pc;
	logic [31:0] rd;
	logic [31:0] seed;
	int          error_cnt;
	int          n_checks;

	eil_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
		.hrdata(hrdata), .hresp(hresp), .irq_pin_n(pin_n), .vec_fetch_ack(ack),
		.cpu_irq_req(req), .pin_level(pin_lvl), .irq(irq));
	eil_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .req(req), .gmask(gmask), .lat(lat),
		.ack(ack), .pc(pc));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [31:0] ctl(input logic t, input logic m, input logic f,
		input logic p);
		return {27'h0, p, f, 1'b0, m, t};
	endfunction : ctl

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk

	task automatic pin(input logic v);
		pin_n <= v;
		repeat (6) @(posedge hclk);
	endtask : pin

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		results();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `EIL_HSIZE_WORD;
		hwdata = 32'h0;
		pin_n = 1'b1;
		gmask = 1'b1;
		lat = 4'h0;
		seed = 32'h42;
		error_cnt = 0;
		n_checks = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("ctrl", `EIL_OFS_CTRL, ctl(0, 0, 0, 1));
		rchk("int_en", `EIL_OFS_INT_EN, 32'h0);
		rchk("unmapped", 8'h10, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		$display("test reset done");
		// Random mode and mask with a stray ack, pin idle
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			bus(1'b1, `EIL_OFS_CTRL, {30'h1, seed[1:0]});
			rchk("ctrl_rw", `EIL_OFS_CTRL, ctl(seed[0], seed[1], 0, 1));
		end
		// Byte-sized write is ignored
		hsize <= 3'h0;
		bus(1'b1, `EIL_OFS_CTRL, ~{30'h0, seed[1:0]});
		hsize <= `EIL_HSIZE_WORD;
		rchk("byte_wr", `EIL_OFS_CTRL, ctl(seed[0], seed[1], 0, 1));
		bus(1'b1, `EIL_OFS_CTRL, 32'h2);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			pin(seed[3]);
			chk("pin_level", {31'h0, seed[3]}, {31'h0, pin_lvl});
		end
		pin(1'b1);
		bus(1'b1, `EIL_OFS_CTRL, 32'h4);
		bus(1'b1, `EIL_OFS_INT_CLR, 32'h3);
		$display("test random done");
		// Edge mode, mask, software ack, interrupt
		bus(1'b1, `EIL_OFS_INT_EN, 32'h1);
		pin(1'b0);
		rchk("edge_set", `EIL_OFS_CTRL, ctl(0, 0, 1, 0));
		chk("req_irq", 32'h3, {30'h0, req, irq});
		bus(1'b1, `EIL_OFS_CTRL, 32'h2);
		pin(1'b0);
		chk("masked", 32'h1, {30'h0, req, irq});
		bus(1'b1, `EIL_OFS_CTRL, 32'h6);
		rchk("edge_ack", `EIL_OFS_CTRL, ctl(0, 1, 0, 0));
		pin(1'b1);
		bus(1'b1, `EIL_OFS_INT_CLR, 32'h3);
		pin(1'b0);
		rchk("edge_again", `EIL_OFS_CTRL, ctl(0, 1, 1, 0));
		rchk("int_stat", `EIL_OFS_INT_STAT, 32'h1);
		bus(1'b1, `EIL_OFS_INT_EN, 32'h0);
		pin(1'b0);
		chk("irq_off", 32'h0, {31'h0, irq});
		bus(1'b1, `EIL_OFS_INT_CLR, 32'h1);
		bus(1'b1, `EIL_OFS_INT_EN, 32'h1);
		pin(1'b0);
		chk("irq_clr", 32'h0, {31'h0, irq});
		$display("test edge done");
		// Vector fetch acknowledge, prompt and slow
		bus(1'b1, `EIL_OFS_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			rchk("gmask_hold", `EIL_OFS_CTRL, ctl(0, 0, 1, 0));
			lat <= 4'(i * 5);
			gmask <= 1'b0;
			repeat (12) @(posedge hclk);
			rchk("vec_clr", `EIL_OFS_CTRL, ctl(0, 0, 0, 0));
			chk("vector", 32'hfffa, {16'h0, pc});
			gmask <= 1'b1;
			pin(1'b1);
			pin(1'b0);
		end
		$display("test vector done");
		// Level mode, both orders of ack and pin return
		bus(1'b1, `EIL_OFS_CTRL, 32'h4);
		pin(1'b1);
		bus(1'b1, `EIL_OFS_CTRL, 32'h1);
		pin(1'b0);
		rchk("lvl_set", `EIL_OFS_CTRL, ctl(1, 0, 1, 0));
		bus(1'b1, `EIL_OFS_CTRL, 32'h7);
		rchk("lvl_hold", `EIL_OFS_CTRL, ctl(1, 1, 1, 0));
		chk("lvl_masked", 32'h0, {31'h0, req});
		pin(1'b1);
		rchk("lvl_clr", `EIL_OFS_CTRL, ctl(1, 1, 0, 1));
		pin(1'b0);
		pin(1'b1);
		rchk("lvl_wait", `EIL_OFS_CTRL, ctl(1, 1, 1, 1));
		bus(1'b1, `EIL_OFS_CTRL, 32'h5);
		rchk("lvl_ack", `EIL_OFS_CTRL, ctl(1, 0, 0, 1));
		$display("test level done");
		// Reset in mid-run with the pin held low
		pin(1'b0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		rchk("rst_mid", `EIL_OFS_CTRL, ctl(0, 0, 0, 0));
		chk("rst_req", 32'h0, {31'h0, req});
		$display("test reset2 done");
		results();
	end
endmodule : external_interrupt_latch_bench
